// ===== logic/acis_pkg.sv
// Package with register map, field layout, source codes and carrier types of the ADC input select block.
package acis_pkg;

    localparam int unsigned APB_ADDR_W  = 12;
    localparam int unsigned APB_DATA_W  = 32;

    // Register byte offsets.
    localparam logic [11:0] OFF_MUX_SEL   = 12'h000;
    localparam logic [11:0] OFF_SCAN_MASK = 12'h004;
    localparam logic [11:0] OFF_CTRL      = 12'h008;
    localparam logic [11:0] OFF_STATUS    = 12'h00C;

    // Input mux select register layout.
    localparam int unsigned SEL_W          = 4;
    localparam int unsigned SB_NEG_BIT     = 31;
    localparam int unsigned SB_POS_LSB     = 24;
    localparam int unsigned SA_NEG_BIT     = 23;
    localparam int unsigned SA_POS_LSB     = 16;
    localparam logic [31:0] MUX_SEL_WMASK  = 32'h8F8F_0000;
    localparam logic [31:0] MUX_SEL_RST    = 32'h0000_0000;

    // Scan mask register layout.
    localparam int unsigned SCAN_W         = 16;
    localparam logic [15:0] SCAN_MASK_RST  = 16'h0000;

    // Control register layout.
    localparam int unsigned CTRL_ALT_BIT    = 0;
    localparam int unsigned CTRL_SCAN_BIT   = 1;
    localparam int unsigned CTRL_OFFSET_CALIBRATION_MODE_BIT = 2;
    localparam int unsigned CTRL_W          = 3;
    localparam logic [2:0]  CTRL_RST        = 3'h0;

    // Status register layout.
    localparam int unsigned STAT_SRC_LSB   = 0;
    localparam int unsigned STAT_NEG_BIT   = 8;
    localparam int unsigned STAT_USEB_BIT  = 9;
    localparam int unsigned STAT_SCAN_LSB  = 12;

    // Selector codes.
    localparam logic [3:0] SEL_LAST_AN = 4'hC;
    localparam logic [3:0] SEL_TEMP    = 4'hD;
    localparam logic [3:0] SEL_IREF    = 4'hE;
    localparam logic [3:0] SEL_OPEN    = 4'hF;

    // Scan mask bit meanings above the analog inputs.
    localparam logic [3:0] SCAN_CHARGE_TIME_MEASURE_UNIT_IDX = 4'hD;
    localparam logic [3:0] SCAN_IREF_IDX = 4'hE;
    localparam logic [3:0] SCAN_GND_IDX  = 4'hF;

    // Converter positive source codes; analog inputs use their own index.
    localparam int unsigned SRC_W      = 5;
    localparam logic [4:0] SRC_TEMP    = 5'h0D;
    localparam logic [4:0] SRC_IREF    = 5'h0E;
    localparam logic [4:0] SRC_OPEN    = 5'h0F;
    localparam logic [4:0] SRC_GND     = 5'h10;
    localparam logic [4:0] SRC_LOWREF  = 5'h11;
    localparam logic [4:0] SRC_CHARGE_TIME_MEASURE_UNIT_IN = 5'h12;

    localparam int unsigned NUM_AN_DEF = 13;

    typedef enum logic [2:0] {
        ST_FIRST = 3'b001,
        ST_B     = 3'b010,
        ST_A     = 3'b100
    } acis_state_t;

    typedef struct packed {
        logic [4:0] pos_src;
        logic       neg_an1;
        logic       use_b;
        logic       scanning;
        logic [3:0] scan_idx;
    } acis_sel_t;

endpackage

// ===== logic/acis_scan_pick.sv
// Finds the first set scan mask bit at or after a start index, wrapping round.
`timescale 1ns/10ps
`default_nettype none
module acis_scan_pick #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic [WIDTH-1:0]         mask_i,
    input  wire logic [$clog2(WIDTH)-1:0] start_i,
    output logic                          found_o,
    output logic [$clog2(WIDTH)-1:0]      index_o
);
    localparam int unsigned IW = $clog2(WIDTH);

    logic [WIDTH-1:0] rot;
    logic [IW-1:0]    offset;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_rot
            wire [IW-1:0] src_idx = start_i + IW'(g);
            assign rot[g] = mask_i[src_idx];
        end
    endgenerate

    // Highest position is checked first so the lowest offset wins.
    always_comb begin
        offset = '0;
        for (int k = WIDTH - 1; k >= 0; k--) begin
            if (rot[k]) begin
                offset = IW'(k);
            end
        end
    end

    assign found_o = |mask_i;
    assign index_o = start_i + offset;
endmodule // acis_scan_pick
`default_nettype wire

// ===== logic/acis_src_map.sv
// Maps a selector code or a scan index to the converter positive source code.
`timescale 1ns/10ps
`default_nettype none
module acis_src_map
    import acis_pkg::*;
#(
    parameter int unsigned NUM_AN = 13
) (
    input  wire logic [3:0] code_i,
    input  wire logic       from_scan_i,
    output logic [4:0]      src_o
);
    wire       is_an   = (code_i <= SEL_LAST_AN);
    wire       has_pin = ({1'b0, code_i} < 5'(NUM_AN));
    wire [4:0] an_src  = has_pin ? {1'b0, code_i} : SRC_LOWREF;

    // Scan positions 13 and 15 name other sources than the selector codes do; 14 is the reference in both.
    wire [4:0] scan_hi = (code_i == SCAN_CHARGE_TIME_MEASURE_UNIT_IDX) ? SRC_CHARGE_TIME_MEASURE_UNIT_IN :
                         (code_i == SCAN_IREF_IDX) ? SRC_IREF : SRC_GND;
    wire [4:0] sel_hi  = (code_i == SEL_TEMP) ? SRC_TEMP :
                         (code_i == SEL_IREF) ? SRC_IREF : SRC_OPEN;

    assign src_o = is_an ? an_src : (from_scan_i ? scan_hi : sel_hi);
endmodule // acis_src_map
`default_nettype wire

// ===== logic/acis_top.sv
// ADC input selection: APB registers, sample A/B alternation, scan stepping and calibration override.
//
// Functional notes
// - Sample B negative bit: AN1 or low reference.
// - Sample B positive code: inputs, sensor, reference, open.
// - Sample A negative bit: AN1 or low reference.
// - Sample A positive code, same encoding as B.
// - Sixteen bit scan mask includes or skips inputs.
// - Mask bits 13-15: measurement unit, reference, ground.
// - Missing pins stay writable, convert low reference.
// - Unused register bits read as zero.
// - Alternate mode: A first, then B, A, ...
// - Scan enable steps through masked inputs.
// - Offset calibration forces both inputs to low reference.
`timescale 1ns/10ps
`default_nettype none
module acis_top
    import acis_pkg::*;
#(
    parameter int unsigned NUM_AN = NUM_AN_DEF
) (
    input  wire logic                            clk_i,
    input  wire logic                            reset_n_i,
    input  wire logic                            psel_i,
    input  wire logic                            penable_i,
    input  wire logic                            pwrite_i,
    input  wire logic [acis_pkg::APB_ADDR_W-1:0] paddr_i,
    input  wire logic [acis_pkg::APB_DATA_W-1:0] pwdata_i,
    input  wire logic [3:0]                      pstrb_i,
    output logic [acis_pkg::APB_DATA_W-1:0]      prdata_o,
    output logic                                 pready_o,
    output logic                                 pslverr_o,
    input  wire logic                            seq_restart_i,
    input  wire logic                            sample_req_i,
    output acis_pkg::acis_sel_t                  sel_o
);
    import acis_pkg::*;

    // Register state.
    logic [31:0]       mux_sel_q;
    logic [31:0]       mux_sel_d;
    logic [15:0]       scan_mask_q;
    logic [15:0]       scan_mask_d;
    logic [2:0]        ctrl_q;
    logic [2:0]        ctrl_d;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    acis_state_t       state_q;
    acis_state_t       state_d;
    logic [3:0]        scan_ptr_q;
    logic [3:0]        scan_ptr_d;
    acis_sel_t         sel_q;
    acis_sel_t         sel_d;

    // APB decode. The slave inserts one wait state so that read data and
    // the answer both leave from flip-flops.
    wire        access    = psel_i & penable_i;
    wire        complete  = access & pready_q;
    wire        hit_mux   = (paddr_i == OFF_MUX_SEL);
    wire        hit_scan  = (paddr_i == OFF_SCAN_MASK);
    wire        hit_ctrl  = (paddr_i == OFF_CTRL);
    wire        hit_stat  = (paddr_i == OFF_STATUS);
    wire        mapped    = hit_mux | hit_scan | hit_ctrl | hit_stat;
    wire        wr_en     = complete & pwrite_i & mapped;

    wire [31:0] byte_mask;
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_strb
            assign byte_mask[8*b +: 8] = {8{pstrb_i[b]}};
        end
    endgenerate

    wire [31:0] mux_wmask  = byte_mask & MUX_SEL_WMASK;
    wire [31:0] mux_wr     = (mux_sel_q & ~mux_wmask) | (pwdata_i & mux_wmask);
    wire [15:0] scan_wr    = (scan_mask_q & ~byte_mask[15:0]) | (pwdata_i[15:0] & byte_mask[15:0]);
    wire [2:0]  ctrl_wr    = pstrb_i[0] ? pwdata_i[2:0] : ctrl_q;

    assign mux_sel_d   = (wr_en & hit_mux)  ? mux_wr  : mux_sel_q;
    assign scan_mask_d = (wr_en & hit_scan) ? scan_wr : scan_mask_q;
    assign ctrl_d      = (wr_en & hit_ctrl) ? ctrl_wr : ctrl_q;

    // Field views.
    wire       sb_neg   = mux_sel_q[SB_NEG_BIT];
    wire [3:0] sb_pos   = mux_sel_q[SB_POS_LSB +: SEL_W];
    wire       sa_neg   = mux_sel_q[SA_NEG_BIT];
    wire [3:0] sa_pos   = mux_sel_q[SA_POS_LSB +: SEL_W];
    wire       alt_mode = ctrl_q[CTRL_ALT_BIT];
    wire       scan_en  = ctrl_q[CTRL_SCAN_BIT];
    wire       offset_calibration_mode   = ctrl_q[CTRL_OFFSET_CALIBRATION_MODE_BIT];

    // Read data; unused bits of every register are zero.
    wire [31:0] mux_rd  = mux_sel_q & MUX_SEL_WMASK;
    wire [31:0] scan_rd = {16'h0000, scan_mask_q};
    wire [31:0] ctrl_rd = {29'h0000_0000, ctrl_q};
    wire [31:0] stat_rd = {16'h0000, sel_q.scan_idx, 2'b00, sel_q.use_b, sel_q.neg_an1, 3'b000, sel_q.pos_src};
    wire [31:0] rd_mux  = hit_mux  ? mux_rd  :
                          hit_scan ? scan_rd :
                          hit_ctrl ? ctrl_rd :
                          hit_stat ? stat_rd : 32'h0000_0000;

    wire        pready_d  = access & ~pready_q;
    wire        pslverr_d = access & ~pready_q & ~mapped;
    wire [31:0] prdata_d  = (access & ~pready_q & ~pwrite_i) ? rd_mux : prdata_q;

    // Scan stepping: the picker finds the next included input from the pointer.
    logic       pick_found;
    logic [3:0] pick_idx;

    acis_scan_pick #(
        .WIDTH (SCAN_W)
    ) u_pick (
        .mask_i  (scan_mask_q),
        .start_i (scan_ptr_q),
        .found_o (pick_found),
        .index_o (pick_idx)
    );

    // An empty mask cannot be scanned, so the A selector is used instead.
    wire scanning = scan_en & pick_found;
    // Clearing alternate mode takes effect at once, even with sample B pending.
    wire use_b    = alt_mode & (state_q == ST_B);

    logic [4:0] sa_src;
    logic [4:0] sb_src;
    logic [4:0] scan_src;

    acis_src_map #(
        .NUM_AN (NUM_AN)
    ) u_map_a (
        .code_i      (sa_pos),
        .from_scan_i (1'b0),
        .src_o       (sa_src)
    );

    acis_src_map #(
        .NUM_AN (NUM_AN)
    ) u_map_b (
        .code_i      (sb_pos),
        .from_scan_i (1'b0),
        .src_o       (sb_src)
    );

    acis_src_map #(
        .NUM_AN (NUM_AN)
    ) u_map_scan (
        .code_i      (pick_idx),
        .from_scan_i (1'b1),
        .src_o       (scan_src)
    );

    // Scanning replaces the sample A positive input; sample B keeps its selector.
    wire [4:0] a_src   = scanning ? scan_src : sa_src;
    wire [4:0] pos_sel = use_b ? sb_src : a_src;
    wire       neg_sel = use_b ? sb_neg : sa_neg;

    always_comb begin
        sel_d          = '0;
        sel_d.use_b    = use_b;
        sel_d.scanning = scanning & ~use_b;
        sel_d.scan_idx = pick_idx;
        if (offset_calibration_mode) begin
            sel_d.pos_src = SRC_LOWREF;
            sel_d.neg_an1 = 1'b0;
        end else begin
            sel_d.pos_src = pos_sel;
            sel_d.neg_an1 = neg_sel;
        end
    end

    // Sample order: first sample of a sequence is always A.
    always_comb begin
        state_d = state_q;
        if (seq_restart_i) begin
            state_d = ST_FIRST;
        end else if (sample_req_i) begin
            case (state_q)
                ST_FIRST: begin
                    state_d = alt_mode ? ST_B : ST_A;
                end
                ST_B: begin
                    state_d = ST_A;
                end
                ST_A: begin
                    state_d = alt_mode ? ST_B : ST_A;
                end
                default: begin
                    state_d = ST_FIRST;
                end
            endcase
        end
    end

    // The pointer moves past the input just converted on each A sample.
    always_comb begin
        scan_ptr_d = scan_ptr_q;
        if (seq_restart_i | ~scan_en) begin
            scan_ptr_d = 4'h0;
        end else if (sample_req_i & scanning & ~use_b) begin
            scan_ptr_d = 4'(pick_idx + 4'h1);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mux_sel_q   <= MUX_SEL_RST;
            scan_mask_q <= SCAN_MASK_RST;
            ctrl_q      <= CTRL_RST;
        end else begin
            mux_sel_q   <= mux_sel_d;
            scan_mask_q <= scan_mask_d;
            ctrl_q      <= ctrl_d;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q    <= ST_FIRST;
            scan_ptr_q <= 4'h0;
            sel_q      <= '0;
        end else begin
            state_q    <= state_d;
            scan_ptr_q <= scan_ptr_d;
            sel_q      <= sel_d;
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;
    assign sel_o     = sel_q;

endmodule // acis_top
`default_nettype wire

// ===== verif/acis_top_assertions.sv
// Concurrent checks on the ports of the ADC input select block.
`timescale 1ns/10ps
`default_nettype none
module acis_top_assertions
    import acis_pkg::*;
(
    input wire logic                            clk_i,
    input wire logic                            reset_n_i,
    input wire logic                            psel_i,
    input wire logic                            penable_i,
    input wire logic                            pwrite_i,
    input wire logic [acis_pkg::APB_ADDR_W-1:0] paddr_i,
    input wire logic [acis_pkg::APB_DATA_W-1:0] pwdata_i,
    input wire logic [3:0]                      pstrb_i,
    input wire logic [acis_pkg::APB_DATA_W-1:0] prdata_o,
    input wire logic                            pready_o,
    input wire logic                            pslverr_o,
    input wire logic                            seq_restart_i,
    input wire logic                            sample_req_i,
    input wire acis_pkg::acis_sel_t             sel_o
);
    logic [2:0] ctrl_q;
    wire logic  wr_ctrl = psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFF_CTRL && pstrb_i[0];
    wire logic  mapped  = paddr_i inside {OFF_MUX_SEL, OFF_SCAN_MASK, OFF_CTRL, OFF_STATUS};
    // A shadow of the control register, so mode checks need no internal probes.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) ctrl_q <= CTRL_RST;
        else if (wr_ctrl) ctrl_q <= pwdata_i[2:0];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_ready_wait: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (pready_o && !mapped |-> pslverr_o)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (pready_o && mapped |-> !pslverr_o)
        else $error("error on mapped address");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_mux_unused: assert property (pready_o && !pwrite_i && paddr_i == OFF_MUX_SEL |->
        (prdata_o & ~MUX_SEL_WMASK) == 32'h0000_0000) else $error("unused select bits not zero");
    a_scan_unused: assert property (pready_o && !pwrite_i && paddr_i == OFF_SCAN_MASK |->
        prdata_o[31:16] == 16'h0000) else $error("unused mask bits not zero");
    a_offset_calibration_mode_force: assert property (ctrl_q[2] && $past(ctrl_q[2]) |->
        sel_o.pos_src == SRC_LOWREF && !sel_o.neg_an1) else $error("calibration not forced");
    a_alt_off: assert property (!ctrl_q[0] && !$past(ctrl_q[0]) |-> !sel_o.use_b)
        else $error("sample B used with alternate mode off");
    a_scan_off: assert property (!ctrl_q[1] && !$past(ctrl_q[1]) |-> !sel_o.scanning)
        else $error("scanning with scan disabled");
    a_restart_a: assert property (seq_restart_i |-> ##2 !sel_o.use_b)
        else $error("first sample after restart not A");
endmodule // acis_top_assertions
bind acis_top acis_top_assertions i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .seq_restart_i(seq_restart_i),
    .sample_req_i(sample_req_i), .sel_o(sel_o));
`default_nettype wire

// ===== verif/tb.sv
// Self-checking testbench of the ADC input select block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import acis_pkg::*;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [3:0]  pstrb_i = 4'hF;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        seq_restart_i = 1'b0;
    logic        sample_req_i = 1'b0;
    acis_sel_t   sel_o;
    int          n_fail = 0;
    int          n_tests = 0;
    always #2.5 clk_i = ~clk_i;
    // Ten pins present, so codes 10 to 12 take the missing-pin path.
    acis_top #(.NUM_AN(10)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .seq_restart_i(seq_restart_i),
        .sample_req_i(sample_req_i), .sel_o(sel_o));
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x,
                       input logic xe);
        int k;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 16);
        if (k == 16) begin
            n_fail++;
            complete_run();
        end
        if (!w) chk(prdata_o, x);
        chk({31'h0, pslverr_o}, {31'h0, xe});
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic sel(input logic [4:0] p, input logic n, input logic b, input logic s, input logic [3:0] x);
        repeat (3) @(posedge clk_i);
        #1;
        chk({20'h0, sel_o}, {20'h0, p, n, b, s, x});
    endtask
    task automatic pulse(input logic r);
        @(posedge clk_i);
        if (r) seq_restart_i <= 1'b1;
        else sample_req_i <= 1'b1;
        @(posedge clk_i);
        seq_restart_i <= 1'b0;
        sample_req_i <= 1'b0;
    endtask
    initial begin
        logic [4:0] sp [5] = '{SRC_LOWREF, SRC_CHARGE_TIME_MEASURE_UNIT_IN, SRC_IREF, SRC_GND, 5'h03};
        logic [3:0] si [5] = '{4'hB, 4'hD, 4'hE, 4'hF, 4'h3};
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        apb(0, OFF_MUX_SEL, 0, 32'h0000_0000, 0);
        apb(0, OFF_SCAN_MASK, 0, 32'h0000_0000, 0);
        sel(5'h00, 0, 0, 0, 4'h0);
        apb(1, OFF_MUX_SEL, 32'hFFFF_FFFF, 0, 0);
        apb(0, OFF_MUX_SEL, 0, 32'h8F8F_0000, 0);
        apb(1, OFF_SCAN_MASK, 32'hFFFF_FFFF, 0, 0);
        apb(0, OFF_SCAN_MASK, 0, 32'h0000_FFFF, 0);
        // Only the sample A byte is strobed, so sample B must keep its fields.
        pstrb_i <= 4'h4;
        apb(1, OFF_MUX_SEL, 32'h0000_0000, 0, 0);
        pstrb_i <= 4'hF;
        apb(0, OFF_MUX_SEL, 0, 32'h8F00_0000, 0);
        apb(1, 12'h010, 32'hFFFF_FFFF, 0, 1);
        apb(1, OFF_STATUS, 32'hFFFF_FFFF, 0, 0);
        for (int i = 0; i < 16; i++) begin
            apb(1, OFF_MUX_SEL, {8'h00, i[0], 3'b000, 4'(i), 16'h0000}, 0, 0);
            sel((i < 10) ? 5'(i) : (i < 13) ? SRC_LOWREF : 5'(i), i[0], 0, 0, 4'h0);
        end
        apb(1, OFF_MUX_SEL, 32'h8D05_0000, 0, 0);
        apb(1, OFF_CTRL, 32'h0000_0001, 0, 0);
        pulse(1);
        sel(5'h05, 0, 0, 0, 4'h0);
        pulse(0);
        sel(SRC_TEMP, 1, 1, 0, 4'h0);
        pulse(0);
        sel(5'h05, 0, 0, 0, 4'h0);
        apb(1, OFF_MUX_SEL, 32'h0E05_0000, 0, 0);
        pulse(0);
        sel(SRC_IREF, 0, 1, 0, 4'h0);
        apb(1, OFF_SCAN_MASK, 32'h0000_E808, 0, 0);
        apb(1, OFF_CTRL, 32'h0000_0002, 0, 0);
        sel(5'h03, 0, 0, 1, 4'h3);
        pulse(1);
        sel(5'h03, 0, 0, 1, 4'h3);
        apb(0, OFF_STATUS, 0, 32'h0000_3003, 0);
        apb(0, OFF_CTRL, 0, 32'h0000_0002, 0);
        for (int i = 0; i < 5; i++) begin
            pulse(0);
            sel(sp[i], 0, 0, 1, si[i]);
        end
        apb(1, OFF_SCAN_MASK, 32'h0000_0000, 0, 0);
        pulse(1);
        sel(5'h05, 0, 0, 0, 4'h0);
        apb(1, OFF_MUX_SEL, 32'h0085_0000, 0, 0);
        apb(1, OFF_CTRL, 32'h0000_0004, 0, 0);
        sel(SRC_LOWREF, 0, 0, 0, 4'h0);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        apb(0, OFF_MUX_SEL, 0, 32'h0000_0000, 0);
        sel(5'h00, 0, 0, 0, 4'h0);
        complete_run();
    end
endmodule // tb
`default_nettype wire
